// *** decoder_params.svh ***
// Opcode values, field positions and cycle counts of the program word decoder
`ifndef DECODER_PARAMS_SVH
`define DECODER_PARAMS_SVH

// Word geometry
`define WORD_W 24
`define OPC_LSB 16
`define OPC_W 8
`define CLS_LSB 5
`define SUB_LSB 2

// Class selector values in opcode bits 7:5
`define CLS_SEL_CTRL 3'h0
`define CLS_SEL_DEFAULT_WORK_REG 3'h2
`define CLS_SEL_BIT 3'h3
`define CLS_SEL_FILE 3'h4
`define CLS_SEL_LIT 3'h5
`define CLS_SEL_MAC 3'h6
`define CLS_SEL_ACC 3'h7

// Control opcodes
`define OPC_NOP 8'h00
`define OPC_JUMP_IND 8'h01
`define OPC_CALL_ABS 8'h02
`define OPC_CALL_IND 8'h03
`define OPC_GOTO_ABS 8'h04
`define OPC_LOOP_ABS 8'h08
`define OPC_BRA 8'h10
`define OPC_BRA_CALC 8'h11
`define OPC_BRA_COND 8'h12
`define OPC_TBL_RD 8'h14
`define OPC_TBL_WR 8'h15
`define OPC_RET_SUB 8'h18
`define OPC_RET_INT 8'h19
`define OPC_SKIP 8'h1C
`define OPC_MOV_DBL 8'h1E

// Arithmetic sub-operations in opcode bits 4:2
`define SUB_ADD 3'h0
`define SUB_ADD_CARRY 3'h1
`define SUB_LOGIC 3'h2
`define SUB_SHIFT 3'h3

// Operand field LSB positions in the low 16 bits
`define F_BASE 12
`define F_SRC 0
`define F_SRC_MODE 4
`define F_DST 6
`define F_DST_MODE 10
`define F_TEN_BIT_CONST 0
`define F_LIT5 0
`define F_MUL_M 14
`define F_MUL_N 12
`define F_XOP 9
`define F_XDST 7
`define F_YOP 4
`define F_YDST 2
`define F_WB 0
`define F_SHIFT_LIT 4

// Fixed registers and limits
`define SUM_WB_REG 4'hD
`define SUM_WB_STEP 2'h2
`define MUL_REG_BASE 4'h4
`define BYTE_LIT_MAX 10'h0FF
`define FILE_ADDR_MAX 13'h1FFF

// Core flag bit positions
`define FLG_C 0
`define FLG_DC 1
`define FLG_N 2
`define FLG_OV 3
`define FLG_Z 4

// Cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3

`endif

// *** decoder_types_pkg.sv ***
// Types shared by the program word decoder files
package decoder_types_pkg;
  typedef enum logic [2:0] {
    CLS_NONE, CLS_WORD_REG, CLS_FILE_REG, CLS_BIT,
    CLS_LITERAL, CLS_MULACC, CLS_ACCUM, CLS_CONTROL
  } op_class_t;
  typedef enum logic [1:0] {
    SIZE_WORD = 2'h0, SIZE_BYTE = 2'h1, SIZE_DOUBLE = 2'h2
  } size_mode_t;
  typedef enum logic [1:0] {
    AM_DIRECT = 2'h0, AM_INDIRECT = 2'h1, AM_POST_INC = 2'h2, AM_PRE_DEC = 2'h3
  } addr_mode_t;
  // Gray codes along fetch -> second and fetch -> skip1 -> skip2; fetch <-> exec and skip2 -> fetch change two bits
  typedef enum logic [2:0] {
    ST_FETCH = 3'h0, ST_SECOND = 3'h1, ST_EXEC = 3'h3, ST_SKIP1 = 3'h2, ST_SKIP2 = 3'h6
  } seq_state_t;
endpackage

// *** prefetch_field_decode.sv ***
// Decodes one 3-bit data space prefetch field into register and step
`timescale 1ns/100ps
module prefetch_field_decode #(
  parameter logic [3:0] BASE_REG = 4'h8
) (
  input wire logic [2:0] op_code,
  input wire logic reg_sel,
  output logic pf_en,
  output logic [3:0] pf_reg,
  output logic [3:0] pf_step
);
  // Code 0 means no prefetch at all
  assign pf_en = (op_code != 3'h0);
  // Second register of the pair when selected
  assign pf_reg = BASE_REG | {3'h0, reg_sel};

  // Step in bytes, two's complement
  always_comb begin
    unique case (op_code)
      3'h2: pf_step = 4'h2;
      3'h3: pf_step = 4'h4;
      3'h4: pf_step = 4'h6;
      3'h5: pf_step = 4'hE;
      3'h6: pf_step = 4'hC;
      3'h7: pf_step = 4'hA;
      default: pf_step = 4'h0;
    endcase
  end
endmodule

// *** instruction_word_decoder.sv ***
// Program word decoder with fetch sequencing and cycle counting
`include "decoder_params.svh"
`timescale 1ns/100ps
module instruction_word_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [23:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic cond_true,
  input wire logic skip_taken,
  output logic dec_valid,
  output decoder_types_pkg::op_class_t dec_class,
  output logic [7:0] dec_opcode,
  output logic two_word,
  output logic [1:0] cycle_count,
  output decoder_types_pkg::size_mode_t size_mode,
  output logic [3:0] base_work_reg,
  output logic [3:0] source_work_reg,
  output decoder_types_pkg::addr_mode_t source_mode,
  output logic [3:0] dest_work_reg,
  output decoder_types_pkg::addr_mode_t dest_mode,
  output logic [12:0] file_addr,
  output logic dest_is_file,
  output logic [3:0] default_work_reg,
  output logic [3:0] bit_position_field,
  output logic bit_from_reg,
  output logic [9:0] ten_bit_const,
  output logic [4:0] short_const,
  output logic acc_select,
  output logic [3:0] mul_reg_m,
  output logic [3:0] mul_reg_n,
  output logic x_pf_en,
  output logic [3:0] x_pf_reg,
  output logic [3:0] x_pf_step,
  output logic [3:0] x_pf_dest,
  output logic y_pf_en,
  output logic [3:0] y_pf_reg,
  output logic [3:0] y_pf_step,
  output logic [3:0] y_pf_dest,
  output logic sum_writeback_en,
  output logic [3:0] sum_writeback_dest,
  output logic [1:0] sum_writeback_step,
  output logic shift_from_reg,
  output logic [5:0] shift_const,
  output logic [22:0] even_program_const,
  output logic [4:0] core_flag_mask,
  output logic sticky_zero_clear_only,
  output logic first_sum_overflow_upd,
  output logic second_sum_overflow_upd,
  output logic first_sum_clipped_upd,
  output logic second_sum_clipped_upd,
  output logic word_fault
);

  // Class from the top opcode bits
  function automatic decoder_types_pkg::op_class_t class_of(input logic [7:0] opc);
    unique case (opc[7:`CLS_LSB])
      `CLS_SEL_CTRL: class_of = (opc == `OPC_NOP) ? decoder_types_pkg::CLS_NONE
                                                  : decoder_types_pkg::CLS_CONTROL;
      `CLS_SEL_DEFAULT_WORK_REG: class_of = decoder_types_pkg::CLS_WORD_REG;
      `CLS_SEL_BIT: class_of = decoder_types_pkg::CLS_BIT;
      `CLS_SEL_FILE: class_of = decoder_types_pkg::CLS_FILE_REG;
      `CLS_SEL_LIT: class_of = decoder_types_pkg::CLS_LITERAL;
      `CLS_SEL_MAC: class_of = decoder_types_pkg::CLS_MULACC;
      `CLS_SEL_ACC: class_of = decoder_types_pkg::CLS_ACCUM;
      default: class_of = decoder_types_pkg::CLS_NONE;
    endcase
  endfunction

  // Only three opcodes span two program words
  function automatic logic is_two_word(input logic [7:0] opc);
    is_two_word = (opc == `OPC_CALL_ABS) || (opc == `OPC_GOTO_ABS) ||
                  (opc == `OPC_LOOP_ABS);
  endfunction

  // Cycles of a single-word instruction
  function automatic logic [1:0] cycles_of(input logic [7:0] opc, input logic cond);
    unique case (opc)
      `OPC_BRA_COND: cycles_of = cond ? `CYC_TWO : `CYC_ONE;
      `OPC_BRA, `OPC_BRA_CALC, `OPC_JUMP_IND, `OPC_CALL_IND,
      `OPC_TBL_RD, `OPC_TBL_WR: cycles_of = `CYC_TWO;
      `OPC_RET_SUB, `OPC_RET_INT: cycles_of = `CYC_THREE;
      `OPC_MOV_DBL: cycles_of = `CYC_TWO;
      default: cycles_of = `CYC_ONE;
    endcase
  endfunction

  // Sequencer and captured words
  decoder_types_pkg::seq_state_t state_reg, state_next;
  logic [23:0] word1_reg;
  logic [23:0] word2_reg;
  logic dec_valid_reg, dec_valid_next;
  logic [1:0] cycles_reg, cycles_next;
  logic [1:0] remain_reg, remain_next;

  // Word taken this cycle and facts about it
  wire take = instr_valid && instr_ready;
  wire [7:0] in_opc = instr_word[23:`OPC_LSB];
  wire in_two = is_two_word(in_opc);
  wire skip_go = (in_opc == `OPC_SKIP) && skip_taken;
  wire [1:0] in_cycles = cycles_of(in_opc, cond_true);
  wire in_fetch = (state_reg == decoder_types_pkg::ST_FETCH);

  // Stall only while extra cycles of a decoded instruction run
  // Two-word and skip sequences fetch in their extra cycles
  assign instr_ready = (state_reg != decoder_types_pkg::ST_EXEC);

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      decoder_types_pkg::ST_FETCH: begin
        if (instr_valid) begin
          if (in_two) begin
            state_next = decoder_types_pkg::ST_SECOND;
          end else if (skip_go) begin
            state_next = decoder_types_pkg::ST_SKIP1;
          end else if (in_cycles != `CYC_ONE) begin
            state_next = decoder_types_pkg::ST_EXEC;
          end
        end
      end
      // Second word fetch is the second cycle itself
      decoder_types_pkg::ST_SECOND: begin
        if (instr_valid) begin
          state_next = decoder_types_pkg::ST_FETCH;
        end
      end
      decoder_types_pkg::ST_EXEC: begin
        if (remain_reg == 2'h1) begin
          state_next = decoder_types_pkg::ST_FETCH;
        end
      end
      // Skipped word is swallowed; its length decides the cost
      decoder_types_pkg::ST_SKIP1: begin
        if (instr_valid) begin
          state_next = in_two ? decoder_types_pkg::ST_SKIP2
                              : decoder_types_pkg::ST_FETCH;
        end
      end
      decoder_types_pkg::ST_SKIP2: begin
        if (instr_valid) begin
          state_next = decoder_types_pkg::ST_FETCH;
        end
      end
      default: state_next = decoder_types_pkg::ST_FETCH;
    endcase
  end

  // Decode result is announced the cycle after the last word is taken, together with the first of any stall cycles
  assign dec_valid_next = take && (
    (in_fetch && !in_two && !skip_go) ||
    (state_reg == decoder_types_pkg::ST_SECOND) ||
    (state_reg == decoder_types_pkg::ST_SKIP1 && !in_two) ||
    (state_reg == decoder_types_pkg::ST_SKIP2));

  // Cycle count handed to pipeline control
  assign cycles_next =
    (state_reg == decoder_types_pkg::ST_SECOND) ? `CYC_TWO :
    (state_reg == decoder_types_pkg::ST_SKIP1) ? `CYC_TWO :
    (state_reg == decoder_types_pkg::ST_SKIP2) ? `CYC_THREE : in_cycles;

  // Stall counter: extra cycles run as no-ops
  // Counts down to one, then back to fetch
  assign remain_next = (take && in_fetch && !in_two && !skip_go) ? in_cycles - 2'h1 :
                       (state_reg == decoder_types_pkg::ST_EXEC) ? remain_reg - 2'h1 :
                       remain_reg;

  // State and handshake registers
  // Count is held so pipeline control may read it late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= decoder_types_pkg::ST_FETCH;
      dec_valid_reg <= 1'b0;
      cycles_reg <= `CYC_ONE;
      remain_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      dec_valid_reg <= dec_valid_next;
      if (dec_valid_next) begin
        cycles_reg <= cycles_next;
      end
      remain_reg <= remain_next;
    end
  end

  // Captured program words; a skip keeps the skip instruction itself
  // Second word cleared per first word, so no stale target leaks
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word1_reg <= 24'h000000;
      word2_reg <= 24'h000000;
    end else if (take && in_fetch) begin
      word1_reg <= instr_word;
      word2_reg <= 24'h000000;
    end else if (take && state_reg == decoder_types_pkg::ST_SECOND) begin
      word2_reg <= instr_word;
    end
  end

  // Views of the captured first word
  wire [7:0] opc = word1_reg[23:`OPC_LSB];
  wire [15:0] ops = word1_reg[15:0];
  wire [2:0] sub_op = opc[4:`SUB_LSB];
  wire [1:0] wb_code = ops[`F_WB +: 2];
  wire arith_cls = (dec_class == decoder_types_pkg::CLS_WORD_REG) ||
                   (dec_class == decoder_types_pkg::CLS_FILE_REG) ||
                   (dec_class == decoder_types_pkg::CLS_LITERAL);
  wire dsp_cls = (dec_class == decoder_types_pkg::CLS_MULACC) ||
                 (dec_class == decoder_types_pkg::CLS_ACCUM);
  // Literal op carries its own destination only when it differs
  wire lit_has_dest = opc[`SUB_LSB];

  // A lone second word has a zero opcode, so it decodes as no-op
  assign dec_class = class_of(opc);
  assign dec_opcode = opc;
  assign dec_valid = dec_valid_reg;
  assign two_word = is_two_word(opc);
  assign cycle_count = cycles_reg;

  // Size selector; the spare code falls back to word
  // A bad suffix then never widens the access
  assign size_mode = (dec_class == decoder_types_pkg::CLS_FILE_REG) ?
    (opc[1] ? decoder_types_pkg::SIZE_BYTE : decoder_types_pkg::SIZE_WORD) :
    (opc[1:0] == 2'h1) ? decoder_types_pkg::SIZE_BYTE :
    (opc[1:0] == 2'h2) ? decoder_types_pkg::SIZE_DOUBLE :
    decoder_types_pkg::SIZE_WORD;

  // Register operands, four bits each
  assign base_work_reg = ops[`F_BASE +: 4];
  assign source_work_reg = ops[`F_SRC +: 4];
  assign source_mode = decoder_types_pkg::addr_mode_t'(ops[`F_SRC_MODE +: 2]);
  // Literal op without own destination writes back to the base register
  assign dest_work_reg = (dec_class == decoder_types_pkg::CLS_LITERAL && !lit_has_dest) ?
                         ops[`F_BASE +: 4] : ops[`F_DST +: 4];
  assign dest_mode = (dec_class == decoder_types_pkg::CLS_LITERAL && !lit_has_dest) ?
    decoder_types_pkg::AM_DIRECT :
    decoder_types_pkg::addr_mode_t'(ops[`F_DST_MODE +: 2]);

  // File register operand; bit ops use a shorter address
  // Bit ops spend the top bits on the bit position
  assign file_addr = (dec_class == decoder_types_pkg::CLS_BIT) ? {1'b0, ops[11:0]} :
                     (ops[12:0] & `FILE_ADDR_MAX);
  assign dest_is_file = opc[0];
  assign default_work_reg = 4'h0;

  // Bit selection by literal or by base register contents
  assign bit_position_field = ops[`F_BASE +: 4];
  assign bit_from_reg = (dec_class == decoder_types_pkg::CLS_BIT) && opc[0];

  // Literals
  assign ten_bit_const = ops[`F_TEN_BIT_CONST +: 10];
  assign short_const = ops[`F_LIT5 +: 5];

  // Accumulator select and multiplicand pair from W4..W7
  assign acc_select = opc[0];
  assign mul_reg_m = `MUL_REG_BASE | {2'h0, ops[`F_MUL_M +: 2]};
  assign mul_reg_n = `MUL_REG_BASE | {2'h0, ops[`F_MUL_N +: 2]};

  // X and Y space prefetch decode, one unit each
  // Pair member comes from the opcode to spare operand bits
  prefetch_field_decode #(.BASE_REG(4'h8)) x_pf_unit (
    .op_code(ops[`F_XOP +: 3]),
    .reg_sel(opc[1]),
    .pf_en(x_pf_en),
    .pf_reg(x_pf_reg),
    .pf_step(x_pf_step)
  );
  prefetch_field_decode #(.BASE_REG(4'hA)) y_pf_unit (
    .op_code(ops[`F_YOP +: 3]),
    .reg_sel(opc[2]),
    .pf_en(y_pf_en),
    .pf_reg(y_pf_reg),
    .pf_step(y_pf_step)
  );
  assign x_pf_dest = `MUL_REG_BASE | {2'h0, ops[`F_XDST +: 2]};
  assign y_pf_dest = `MUL_REG_BASE | {2'h0, ops[`F_YDST +: 2]};

  // Writeback: code 1 direct W13, code 2 indirect with step of two
  assign sum_writeback_en = (dec_class == decoder_types_pkg::CLS_MULACC) &&
                            (wb_code == 2'h1 || wb_code == 2'h2);
  assign sum_writeback_dest = `SUM_WB_REG;
  assign sum_writeback_step = (wb_code == 2'h2) ? `SUM_WB_STEP : 2'h0;

  // Shift amount from a register or a literal
  assign shift_from_reg = opc[1];
  assign shift_const = ops[`F_SHIFT_LIT +: 6];

  // Program address spans both words
  assign even_program_const = {word2_reg[6:0], word1_reg[15:0]};

  // Core flags touched by arithmetic, logic and shift groups
  assign core_flag_mask =
    !arith_cls ? 5'h00 :
    (sub_op == `SUB_ADD || sub_op == `SUB_ADD_CARRY) ? 5'h1F :
    (sub_op == `SUB_LOGIC) ? ((5'h01 << `FLG_N) | (5'h01 << `FLG_Z)) :
    (sub_op == `SUB_SHIFT) ? ((5'h01 << `FLG_C) | (5'h01 << `FLG_N) |
                              (5'h01 << `FLG_OV) | (5'h01 << `FLG_Z)) : 5'h00;
  // Multi-word arithmetic may only clear the sticky zero flag
  assign sticky_zero_clear_only = arith_cls && (sub_op == `SUB_ADD_CARRY);

  // Accumulator flags, kept apart per accumulator
  assign first_sum_overflow_upd = dsp_cls && !acc_select;
  assign first_sum_clipped_upd = dsp_cls && !acc_select;
  assign second_sum_overflow_upd = dsp_cls && acc_select;
  assign second_sum_clipped_upd = dsp_cls && acc_select;

  // Malformed words: flagged, not trapped, so the pipeline decides
  // Trapping here would need a path back into fetch
  assign word_fault =
    (two_word && word2_reg[23:16] != 8'h00) ||
    (two_word && word1_reg[0]) ||
    (dec_class == decoder_types_pkg::CLS_LITERAL && !lit_has_dest &&
     size_mode == decoder_types_pkg::SIZE_BYTE && ten_bit_const > `BYTE_LIT_MAX) ||
    (dec_class == decoder_types_pkg::CLS_MULACC && wb_code == 2'h3) ||
    (opc[7:`CLS_LSB] == 3'h1);

endmodule

// *** prog_mem_model.sv ***
// Program memory stand-in that offers words to the decoder
`timescale 1ns/100ps
module prog_mem_model (
  input wire logic core_clk,
  input wire logic instr_ready,
  output logic [23:0] instr_word,
  output logic instr_valid
);
  logic [23:0] q[$]; // Words still to be offered
  logic taken; // Head word accepted at last rising edge
  logic slow; // Idle one cycle after each accepted word
  logic gap;
  initial begin
    taken = 1'b0;
    slow = 1'b0;
    instr_valid = 1'b0;
    instr_word = 24'hA5A5A5;
  end
  task automatic push(input logic [23:0] w);
    q.push_back(w);
  endtask
  // Acceptance seen on the decoder's sampling edge
  always @(posedge core_clk) begin
    taken <= instr_valid && instr_ready;
  end
  // Word held until taken; idle bus shows inverted data, not a stale copy
  always @(negedge core_clk) begin
    if (taken && q.size() > 0) begin
      void'(q.pop_front());
    end
    gap = taken && slow;
    if (q.size() > 0 && !gap) begin
      instr_word <= q[0];
      instr_valid <= 1'b1;
    end else begin
      instr_word <= ~instr_word;
      instr_valid <= 1'b0;
    end
  end
endmodule

// *** decoder_chk.sv ***
// Port-level timing and field checks for the program word decoder
`include "decoder_params.svh"
`timescale 1ns/100ps
module decoder_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instr_ready,
  input wire logic cond_true,
  input wire logic dec_valid,
  input wire decoder_types_pkg::op_class_t dec_class,
  input wire logic [7:0] dec_opcode,
  input wire logic two_word,
  input wire logic [1:0] cycle_count,
  input wire logic [3:0] base_work_reg,
  input wire logic [3:0] dest_work_reg,
  input wire decoder_types_pkg::addr_mode_t dest_mode,
  input wire logic dest_is_file,
  input wire logic [3:0] default_work_reg,
  input wire logic sum_writeback_en,
  input wire logic [3:0] sum_writeback_dest,
  input wire logic [1:0] sum_writeback_step,
  input wire logic [22:0] even_program_const,
  input wire logic word_fault
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Data classes finish in one cycle with no stall
  a_plain_one_cycle: assert property (dec_valid && dec_class inside {decoder_types_pkg::CLS_WORD_REG,
    decoder_types_pkg::CLS_FILE_REG, decoder_types_pkg::CLS_BIT, decoder_types_pkg::CLS_LITERAL}
    |-> cycle_count == 2'h1 && instr_ready) else $error("data op not single cycle");
  // Conditional branch cost follows the test sampled with the word
  a_cond_cycles: assert property (dec_valid && dec_opcode == `OPC_BRA_COND
    |-> cycle_count == ($past(cond_true) ? 2'h2 : 2'h1)) else $error("cond branch count");
  // Returns stall two cycles
  a_return_stall: assert property (dec_valid && dec_opcode inside {`OPC_RET_SUB, `OPC_RET_INT}
    |-> cycle_count == 2'h3 && !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("return stall wrong");
  // Branches, indirect jumps and tables stall one cycle
  a_branch_stall: assert property (dec_valid && dec_opcode inside {`OPC_BRA, `OPC_BRA_CALC,
    `OPC_JUMP_IND, `OPC_CALL_IND, `OPC_TBL_RD, `OPC_TBL_WR}
    |-> cycle_count == 2'h2 && !instr_ready ##1 instr_ready) else $error("branch stall wrong");
  // Double move costs two cycles
  a_double_move: assert property (dec_valid && dec_opcode == `OPC_MOV_DBL
    |-> cycle_count == 2'h2 && !instr_ready ##1 instr_ready) else $error("double move count");
  // Two-word forms: two cycles, extra cycle is the second fetch
  a_two_word_count: assert property (dec_valid && dec_opcode inside {`OPC_CALL_ABS,
    `OPC_GOTO_ABS, `OPC_LOOP_ABS} |-> two_word && cycle_count == 2'h2 && instr_ready)
    else $error("two-word count");
  // Odd program target must be flagged
  a_odd_target: assert property (dec_valid && dec_opcode inside {`OPC_CALL_ABS, `OPC_GOTO_ABS}
    && even_program_const[0] |-> word_fault) else $error("odd target not flagged");
  // Literal result returns to the base register
  a_lit_dest: assert property (dec_valid && dec_class == decoder_types_pkg::CLS_LITERAL
    && !dec_opcode[2] |-> dest_work_reg == base_work_reg
    && dest_mode == decoder_types_pkg::AM_DIRECT) else $error("literal dest not base");
  // Write-back only to register 13, step zero or two
  a_sum_dest: assert property (dec_valid && sum_writeback_en |-> sum_writeback_dest == 4'hD
    && sum_writeback_step inside {2'h0, 2'h2}) else $error("writeback dest wrong");
  // File destination bit and register zero as default
  a_file_dest: assert property (dec_valid && dec_class == decoder_types_pkg::CLS_FILE_REG
    |-> dest_is_file == dec_opcode[0] && default_work_reg == 4'h0) else $error("file dest wrong");
endmodule
bind instruction_word_decoder decoder_chk chk_i (.core_clk(core_clk), .rst(rst),
  .instr_ready(instr_ready), .cond_true(cond_true), .dec_valid(dec_valid),
  .dec_class(dec_class), .dec_opcode(dec_opcode), .two_word(two_word),
  .cycle_count(cycle_count), .base_work_reg(base_work_reg), .dest_work_reg(dest_work_reg),
  .dest_mode(dest_mode), .dest_is_file(dest_is_file), .default_work_reg(default_work_reg),
  .sum_writeback_en(sum_writeback_en), .sum_writeback_dest(sum_writeback_dest),
  .sum_writeback_step(sum_writeback_step), .even_program_const(even_program_const),
  .word_fault(word_fault));

// *** instruction_word_decoder_tb.sv ***
// Self-checking bench for the program word decoder
`include "decoder_params.svh"
`timescale 1ns/100ps
module instruction_word_decoder_tb;
  logic core_clk, rst, cond_true, skip_taken, instr_valid, instr_ready;
  logic [23:0] instr_word;
  logic dec_valid, two_word, dest_is_file, bit_from_reg, acc_select, x_pf_en, y_pf_en;
  logic sum_writeback_en, shift_from_reg, sticky_zero_clear_only, word_fault;
  logic first_sum_overflow_upd, second_sum_overflow_upd;
  logic first_sum_clipped_upd, second_sum_clipped_upd;
  decoder_types_pkg::op_class_t dec_class;
  decoder_types_pkg::size_mode_t size_mode;
  decoder_types_pkg::addr_mode_t source_mode, dest_mode;
  logic [7:0] dec_opcode;
  logic [1:0] cycle_count, sum_writeback_step;
  logic [3:0] base_work_reg, source_work_reg, dest_work_reg, default_work_reg;
  logic [3:0] bit_position_field, mul_reg_m, mul_reg_n, sum_writeback_dest;
  logic [3:0] x_pf_reg, x_pf_step, x_pf_dest, y_pf_reg, y_pf_step, y_pf_dest;
  logic [12:0] file_addr;
  logic [9:0] ten_bit_const;
  logic [5:0] shift_const;
  logic [22:0] even_program_const;
  logic [4:0] core_flag_mask, short_const;
  int n_mismatch, samples_checked;

  instruction_word_decoder dut (.*);
  prog_mem_model mem (.core_clk(core_clk), .instr_ready(instr_ready),
    .instr_word(instr_word), .instr_valid(instr_valid));

  // Free-running core clock, 8 ns
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Four-state compare; an unknown bit matches only the same unknown
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Bounded wait for the decode pulse, sampled on falling edges
  task automatic wait_dec;
    int i;
    i = 0;
    do begin
      @(negedge core_clk);
      i++;
    end while (dec_valid !== 1'b1 && i < 20);
    if (dec_valid !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t no decode pulse", $time);
    end
  endtask

  task automatic t_word_reg;
    logic [2:0] sub [4] = '{`SUB_ADD, `SUB_ADD_CARRY, `SUB_LOGIC, `SUB_SHIFT};
    logic [1:0] sz [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
    logic [1:0] ex_sz [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
    logic [4:0] mask [4] = '{5'h1F, 5'h1F, 5'h14, 5'h1D};
    // Back to back, one per size code
    for (int i = 0; i < 4; i++) mem.push({`CLS_SEL_DEFAULT_WORK_REG, sub[i], sz[i], 16'hA95F});
    for (int i = 0; i < 4; i++) begin
      wait_dec;
      chk(size_mode, ex_sz[i]);
      chk(core_flag_mask, mask[i]);
      chk(sticky_zero_clear_only, i == 1);
    end
    chk({base_work_reg, source_work_reg, dest_work_reg, source_mode, dest_mode},
      {4'hA, 4'hF, 4'h5, 2'h1, 2'h2});
    chk(short_const, 5'h1F);
    $display("t_word_reg done");
  endtask

  task automatic t_file;
    mem.slow = 1'b1;
    mem.push({8'h81, 16'h1FFF});
    mem.push({8'h82, 16'h0000});
    wait_dec;
    chk({file_addr, dest_is_file, default_work_reg, size_mode}, {13'h1FFF, 5'h10, 2'h0});
    wait_dec;
    chk({file_addr, dest_is_file, default_work_reg, size_mode}, {13'h0, 5'h00, 2'h1});
    mem.slow = 1'b0;
    $display("t_file done");
  endtask

  task automatic t_bit;
    mem.push({8'h61, 16'hF123});
    mem.push({8'h60, 16'h0ABC});
    wait_dec;
    chk({bit_position_field, bit_from_reg, file_addr}, {4'hF, 1'b1, 13'h0123});
    wait_dec;
    chk({bit_position_field, bit_from_reg, file_addr}, {4'h0, 1'b0, 13'h0ABC});
    $display("t_bit done");
  endtask

  task automatic t_literal;
    mem.push({8'hA0, 16'h33FF});
    mem.push({8'hA1, 16'h20FF});
    mem.push({8'hA1, 16'h2100});
    wait_dec;
    chk({dest_work_reg, dest_mode, ten_bit_const, word_fault}, {4'h3, 2'h0, 10'h3FF, 1'b0});
    wait_dec;
    chk({dest_work_reg, dest_mode, ten_bit_const, word_fault}, {4'h2, 2'h0, 10'h0FF, 1'b0});
    wait_dec;
    chk({ten_bit_const, word_fault}, {10'h100, 1'b1});
    $display("t_literal done");
  endtask

  task automatic t_dsp;
    mem.push({8'hC7, 16'h65F2});
    mem.push({8'hC0, 16'h0003});
    mem.push({8'hE3, 16'h02A0});
    wait_dec;
    chk({mul_reg_m, mul_reg_n, x_pf_en, x_pf_reg, x_pf_step, x_pf_dest},
      {4'h5, 4'h6, 1'b1, 4'h9, 4'h2, 4'h7});
    chk({y_pf_en, y_pf_reg, y_pf_step, y_pf_dest, acc_select}, {1'b1, 4'hB, 4'hA, 4'h4, 1'b1});
    chk({sum_writeback_en, sum_writeback_dest, sum_writeback_step, word_fault}, 8'hEC);
    chk({first_sum_overflow_upd, second_sum_overflow_upd, first_sum_clipped_upd,
      second_sum_clipped_upd}, 4'b0101);
    wait_dec;
    chk({x_pf_en, y_pf_en, word_fault, first_sum_overflow_upd, second_sum_overflow_upd}, 5'b00110);
    wait_dec;
    chk({dec_class, acc_select, shift_from_reg, shift_const, first_sum_overflow_upd,
      second_sum_overflow_upd}, {decoder_types_pkg::CLS_ACCUM, 8'hEA, 2'b01});
    $display("t_dsp done");
  endtask

  task automatic t_control;
    logic [7:0] op [10] = '{`OPC_NOP, `OPC_BRA, `OPC_BRA_CALC, `OPC_JUMP_IND, `OPC_CALL_IND,
      `OPC_TBL_RD, `OPC_TBL_WR, `OPC_MOV_DBL, `OPC_RET_SUB, `OPC_RET_INT};
    logic [1:0] cy [10] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 10; i++) mem.push({op[i], 16'h0000});
    for (int i = 0; i < 10; i++) begin
      wait_dec;
      chk({cycle_count, instr_ready}, {cy[i], cy[i] == 2'h1});
    end
    // Conditional branch, test false then true
    for (int c = 0; c < 2; c++) begin
      cond_true = c[0];
      mem.push({`OPC_BRA_COND, 16'h0000});
      wait_dec;
      chk(cycle_count, c[0] ? 2'h2 : 2'h1);
    end
    cond_true = 1'b0;
    $display("t_control done");
  endtask

  task automatic t_two_word;
    mem.push({`OPC_GOTO_ABS, 16'h1234});
    mem.push(24'h000056);
    wait_dec;
    chk({two_word, cycle_count, instr_ready, word_fault, even_program_const},
      {1'b1, 2'h2, 2'b10, 23'h561234});
    mem.push(24'h000056);
    wait_dec;
    chk({dec_opcode, cycle_count, two_word}, {8'h00, 2'h1, 1'b0});
    mem.push({`OPC_CALL_ABS, 16'h0001});
    mem.push(24'h000000);
    wait_dec;
    chk(word_fault, 1'b1);
    mem.push({`OPC_LOOP_ABS, 16'h0000});
    mem.push(24'h010000);
    wait_dec;
    chk({two_word, word_fault}, 2'b11);
    $display("t_two_word done");
  endtask

  task automatic t_skip;
    skip_taken = 1'b1;
    mem.push({`OPC_SKIP, 16'h0000});
    mem.push({`OPC_GOTO_ABS, 16'h0000});
    mem.push(24'h000000);
    wait_dec;
    chk(cycle_count, 2'h3);
    mem.push({`OPC_SKIP, 16'h0000});
    mem.push({`OPC_NOP, 16'h0000});
    wait_dec;
    chk(cycle_count, 2'h2);
    skip_taken = 1'b0;
    mem.push({`OPC_SKIP, 16'h0000});
    wait_dec;
    chk(cycle_count, 2'h1);
    $display("t_skip done");
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence; inputs move on falling edges
  initial begin
    rst = 1'b1;
    cond_true = 1'b0;
    skip_taken = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    t_word_reg;
    t_file;
    t_bit;
    t_literal;
    t_dsp;
    t_control;
    t_two_word;
    t_skip;
    summarize;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #40000;
    n_mismatch++;
    summarize;
  end
endmodule
